// ### core/wdp_defs.vh
`ifndef WDP_DEFS_VH
`define WDP_DEFS_VH
// Serial frame layout
`define WDP_FRAME_BITS 5'd16
`define WDP_HDR_BITS 5'd4
`define WDP_ADDR_HI 15
`define WDP_ADDR_LO 14
`define WDP_FSEL_BIT 13
`define WDP_RO_BIT 12
`define WDP_PC_HI 11
`define WDP_PC_LO 6
`define WDP_OM_HI 5
`define WDP_OM_LO 3
`define WDP_SDM_BIT 2
`define WDP_EN_BIT 1
`define WDP_ADDR_MODE 2'h0
`define WDP_FSEL_STATUS 1'b0
// Operating mode codes
`define WDP_OM_NONE 3'h0
`define WDP_OM_NORMAL 3'h1
`define WDP_OM_STANDBY 3'h2
`define WDP_OM_INIT_FLASH 3'h3
`define WDP_OM_SLEEP 3'h4
`define WDP_OM_INIT_NORMAL 3'h5
`define WDP_OM_LEAVE_FLASH 3'h6
`define WDP_OM_FLASH 3'h7
// Mode classes for the period lookup
`define WDP_MC_NORMAL 2'h0
`define WDP_MC_STANDBY 2'h1
`define WDP_MC_FLASH 2'h2
`define WDP_MC_SLEEP 2'h3
// Legal period codes, shortest first
`define WDP_PC_0 6'h09
`define WDP_PC_1 6'h0c
`define WDP_PC_2 6'h12
`define WDP_PC_3 6'h14
`define WDP_PC_4 6'h1b
`define WDP_PC_5 6'h24
`define WDP_PC_6 6'h2d
`define WDP_PC_7 6'h33
`define WDP_PC_8 6'h35
`define WDP_PC_9 6'h36
// Entries that do not follow the prescaler scaling
`define WDP_EXC_NORM_MS 14'd244
`define WDP_EXC_STBY_MS 14'd1560
// Oscillator and system clock rates
`define WDP_OSC_KHZ 18'd512
`define WDP_CLK_KHZ 18'd200000
// Timing counts in oscillator ticks
`define WDP_INIT_TICKS 24'd131072
`define WDP_RST_TICKS 24'd1024
// Reset source codes
`define WDP_RS_POR 4'h0
`define WDP_RS_CYCLIC 4'h1
`define WDP_RS_LOCAL_WAKE 4'h9
`define WDP_RS_WD_OVF 4'hb
`define WDP_RS_WD_INIT 4'hc
`define WDP_RS_ILLEGAL 4'he
// Reset values
`define WDP_OM_RESET 3'h1
`define WDP_PC_RESET 6'h36
`endif

// ### core/wdp_period_lut.v
`timescale 1ns/1ps
`include "wdp_defs.vh"
module wdp_period_lut (
  input wire clk,
  input wire resetn,
  input wire [5:0] code,
  input wire [1:0] presc,
  input wire [1:0] mclass,
  output reg [23:0] ticks_reg
);
  reg [13:0] base;
  reg [2:0] fac;
  reg [15:0] prod;
  reg [23:0] ticks_next;

  // Prescaler 00 values per mode class
  always @* begin
    case (code)
      `WDP_PC_0: base = (mclass == `WDP_MC_NORMAL) ? 14'd4 :
        (mclass == `WDP_MC_SLEEP) ? 14'd160 : 14'd20; // RULE_01
      `WDP_PC_1: base = (mclass == `WDP_MC_NORMAL) ? 14'd8 :
        (mclass == `WDP_MC_SLEEP) ? 14'd320 : 14'd40;
      `WDP_PC_2: base = (mclass == `WDP_MC_NORMAL) ? 14'd16 :
        (mclass == `WDP_MC_SLEEP) ? 14'd640 : 14'd80;
      `WDP_PC_3: base = (mclass == `WDP_MC_NORMAL) ? 14'd32 :
        (mclass == `WDP_MC_SLEEP) ? 14'd1024 : 14'd160;
      `WDP_PC_4: base = (mclass == `WDP_MC_NORMAL) ? 14'd40 :
        (mclass == `WDP_MC_SLEEP) ? 14'd2048 : 14'd320;
      `WDP_PC_5: base = (mclass == `WDP_MC_NORMAL) ? 14'd48 :
        (mclass == `WDP_MC_SLEEP) ? 14'd3072 : 14'd640;
      `WDP_PC_6: base = (mclass == `WDP_MC_NORMAL) ? 14'd56 :
        (mclass == `WDP_MC_SLEEP) ? 14'd4096 : 14'd1024;
      `WDP_PC_7: base = (mclass == `WDP_MC_NORMAL) ? 14'd64 :
        (mclass == `WDP_MC_SLEEP) ? 14'd6144 : 14'd2048;
      `WDP_PC_8: base = (mclass == `WDP_MC_NORMAL) ? 14'd72 :
        (mclass == `WDP_MC_SLEEP) ? 14'd8192 : 14'd4096;
      `WDP_PC_9: base = (mclass == `WDP_MC_NORMAL) ? 14'd80 : 14'd8192;
      default: base = 14'd0;
    endcase
  end

  // Scale in half steps: 1, 1.5, 2.5 and 3.5
  always @* begin
    case (presc)
      2'h0: fac = 3'd2; // RULE_01
      2'h1: fac = 3'd3; // RULE_02
      2'h2: fac = 3'd5; // RULE_03
      2'h3: fac = 3'd7; // RULE_04
      default: fac = 3'd2;
    endcase
  end

  // One millisecond is 512 oscillator ticks, half a millisecond 256
  always @* begin
    prod = {2'b00, base} * {13'h0000, fac};
    ticks_next = {prod, 8'h00}; // RULE_05
    if (presc == 2'h3 && code == `WDP_PC_7 && mclass == `WDP_MC_NORMAL) begin
      ticks_next = {1'b0, `WDP_EXC_NORM_MS, 9'h000}; // RULE_04
    end
    if (presc == 2'h2 && code == `WDP_PC_6 && mclass != `WDP_MC_NORMAL &&
        mclass != `WDP_MC_SLEEP) begin
      ticks_next = {1'b0, `WDP_EXC_STBY_MS, 9'h000}; // RULE_03
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      ticks_reg <= 24'h000000;
    end else begin
      ticks_reg <= ticks_next;
    end
  end
endmodule // wdp_period_lut

// ### core/wdp_spi_slave.v
`timescale 1ns/1ps
`include "wdp_defs.vh"
module wdp_spi_slave (
  input wire clk,
  input wire resetn,
  input wire sclk,
  input wire cs_n,
  input wire sdi,
  input wire [11:0] tx_word,
  output reg sdo_reg,
  output wire sdo_oe,
  output wire hdr_valid,
  output wire [3:0] hdr,
  output reg frame_done_reg,
  output reg [15:0] rx_word_reg
);
  reg sclk_q;
  reg cs_q;
  reg [4:0] cnt_reg;
  reg [15:0] sh_in_reg;
  reg [11:0] sh_out_reg;
  wire rise;
  wire fall;

  assign rise = ~cs_n & sclk & ~sclk_q;
  assign fall = ~cs_n & ~sclk & sclk_q;
  assign hdr_valid = rise && (cnt_reg == `WDP_HDR_BITS - 5'd1);
  assign hdr = {sh_in_reg[2:0], sdi};
  assign sdo_oe = ~cs_n;

  always @(posedge clk) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      cnt_reg <= 5'd0;
      sh_in_reg <= 16'h0000;
      sh_out_reg <= 12'h000;
      sdo_reg <= 1'b0;
      frame_done_reg <= 1'b0;
      rx_word_reg <= 16'h0000;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      frame_done_reg <= 1'b0;
      if (cs_n) begin
        cnt_reg <= 5'd0;
        sdo_reg <= 1'b0;
        if (!cs_q && cnt_reg == `WDP_FRAME_BITS) begin
          frame_done_reg <= 1'b1;
          rx_word_reg <= sh_in_reg;
        end
      end else begin
        if (rise) begin
          sh_in_reg <= {sh_in_reg[14:0], sdi};
          if (cnt_reg != 5'd31) begin
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        if (hdr_valid) begin
          sh_out_reg <= tx_word;
        end
        if (fall && cnt_reg >= `WDP_HDR_BITS) begin
          sdo_reg <= sh_out_reg[11];
          sh_out_reg <= {sh_out_reg[10:0], 1'b0};
        end
      end
    end
  end
endmodule // wdp_spi_slave

// ### core/wdp_top.v
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Prescaler 00 maps the ten legal period codes to Normal timeouts of 4 to 80 ms.
// [RULE_02] Prescaler 01 scales every timeout by one and a half.
// [RULE_03] Prescaler 10 gives Normal 10 to 200 ms and Standby or Flash up to 20480 ms.
// [RULE_04] Prescaler 11 gives Normal 14 to 280 ms and Sleep up to 28672 ms.
// [RULE_05] All periods count ticks of the 512 kHz internal oscillator.
// [RULE_06] Sleep entry with the highest code disables the watchdog at once, reset held low.
// [RULE_07] On Sleep entry the supply is cut only after the reset output is already low.
// [RULE_08] The status word can be read in every operating mode.
// [RULE_09] Address 00 with feedback select 0 returns status; read only 1 leaves the mode word.
// [RULE_10] With read only 0 the frame also writes the mode word.
// [RULE_11] Every mode word write outside reset and Sleep is checked; an illegal code is ignored and forces a reset.
// [RULE_12] After reset release the host must write the mode word within the initial window.
// [RULE_13] Any period value outside the ten codes is an illegal coding.
// [RULE_14] The highest code gives a finite timeout in Normal and Flash but none in Standby.
`include "wdp_defs.vh"
module wdp_top #(
  parameter [17:0] OSC_KHZ = `WDP_OSC_KHZ,
  parameter [17:0] CLK_KHZ = `WDP_CLK_KHZ,
  parameter [23:0] INIT_TICKS = `WDP_INIT_TICKS,
  parameter [23:0] RST_TICKS = `WDP_RST_TICKS
) (
  input wire clk,
  input wire resetn,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe,
  input wire [1:0] period_prescaler,
  input wire [7:0] status_in,
  input wire wake_event,
  output wire reset_output_n,
  output wire mcu_supply,
  output wire [2:0] mode_code,
  output wire sdm_out,
  output wire en_out,
  output wire wd_active
);
  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_WDOFF = 3'h2;
  localparam [2:0] ST_RST = 3'h3;
  localparam [2:0] ST_SLP_ENTRY = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;

  // Period code legality
  function pc_legal;
    input [5:0] pc;
    begin
      case (pc)
        `WDP_PC_0, `WDP_PC_1, `WDP_PC_2, `WDP_PC_3, `WDP_PC_4,
        `WDP_PC_5, `WDP_PC_6, `WDP_PC_7, `WDP_PC_8, `WDP_PC_9: pc_legal = 1'b1;
        default: pc_legal = 1'b0;
      endcase
    end
  endfunction

  // Operating mode code to period class
  function [1:0] mode_class;
    input [2:0] om;
    begin
      case (om)
        `WDP_OM_STANDBY: mode_class = `WDP_MC_STANDBY;
        `WDP_OM_SLEEP: mode_class = `WDP_MC_SLEEP;
        `WDP_OM_INIT_FLASH, `WDP_OM_FLASH: mode_class = `WDP_MC_FLASH;
        default: mode_class = `WDP_MC_NORMAL;
      endcase
    end
  endfunction

  // Highest code switches the timeout off in Standby and Sleep only
  function wd_off;
    input [5:0] pc;
    input [1:0] mc;
    begin
      wd_off = (pc == `WDP_PC_9) &&
        (mc == `WDP_MC_STANDBY || mc == `WDP_MC_SLEEP); // RULE_14
    end
  endfunction

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [23:0] cnt_reg;
  reg [23:0] cnt_next;
  reg [17:0] acc_reg;
  reg [17:0] acc_next;
  reg rst_low_reg;
  reg rst_low_next;
  reg supply_reg;
  reg supply_next;
  reg [3:0] rsrc_reg;
  reg [3:0] rsrc_next;
  reg [2:0] om_reg;
  reg [2:0] om_next;
  reg [5:0] pc_reg;
  reg [5:0] pc_next;
  reg sdm_reg;
  reg sdm_next;
  reg en_reg;
  reg en_next;
  reg [11:0] tx_word;

  wire [18:0] acc_sum;
  wire tick;
  wire [23:0] cnt_inc;
  wire [23:0] period_ticks;
  wire hdr_valid;
  wire [3:0] hdr;
  wire frame_done;
  wire [15:0] rx_word;
  wire mode_wr;
  wire [5:0] new_pc;
  wire [2:0] new_om;
  wire [1:0] new_mc;
  wire new_legal;
  wire sleep_off;

  // Fractional divider: one tick per oscillator period on average
  assign acc_sum = {1'b0, acc_reg} + {1'b0, OSC_KHZ}; // RULE_05
  assign tick = (acc_sum >= {1'b0, CLK_KHZ});
  assign cnt_inc = tick ? cnt_reg + 24'd1 : cnt_reg;

  always @* begin
    if (tick) begin
      acc_next = acc_sum[17:0] - CLK_KHZ;
    end else begin
      acc_next = acc_sum[17:0];
    end
  end

  wdp_spi_slave u_spi (
    .clk(clk),
    .resetn(resetn),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .sdi(spi_sdi),
    .tx_word(tx_word),
    .sdo_reg(spi_sdo),
    .sdo_oe(spi_sdo_oe),
    .hdr_valid(hdr_valid),
    .hdr(hdr),
    .frame_done_reg(frame_done),
    .rx_word_reg(rx_word)
  );

  wdp_period_lut u_lut (
    .clk(clk),
    .resetn(resetn),
    .code(pc_reg),
    .presc(period_prescaler),
    .mclass(mode_class(om_reg)),
    .ticks_reg(period_ticks)
  );

  // Readback choice once the header is in; no dependence on state
  always @* begin
    if (hdr[3:2] == `WDP_ADDR_MODE && hdr[1] == `WDP_FSEL_STATUS) begin
      tx_word = {rsrc_reg, status_in}; // RULE_08 RULE_09
    end else begin
      tx_word = 12'h000;
    end
  end

  // Only frames at the mode address with read only clear write
  assign mode_wr = frame_done && rx_word[`WDP_ADDR_HI:`WDP_ADDR_LO] == `WDP_ADDR_MODE &&
    !rx_word[`WDP_RO_BIT]; // RULE_09 RULE_10
  assign new_pc = rx_word[`WDP_PC_HI:`WDP_PC_LO];
  assign new_om = rx_word[`WDP_OM_HI:`WDP_OM_LO];
  assign new_mc = mode_class(new_om);
  assign new_legal = pc_legal(new_pc) && (new_om != `WDP_OM_NONE); // RULE_11 RULE_13
  assign sleep_off = wd_off(pc_reg, `WDP_MC_SLEEP);

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_inc;
    rst_low_next = rst_low_reg;
    supply_next = supply_reg;
    rsrc_next = rsrc_reg;
    om_next = om_reg;
    pc_next = pc_reg;
    sdm_next = sdm_reg;
    en_next = en_reg;
    case (state_reg)
      ST_INIT, ST_RUN, ST_WDOFF: begin
        if (mode_wr && !new_legal) begin
          state_next = ST_RST; // RULE_11
          rsrc_next = `WDP_RS_ILLEGAL;
          rst_low_next = 1'b1;
          cnt_next = 24'd0;
        end else if (mode_wr) begin
          om_next = new_om; // RULE_10
          pc_next = new_pc;
          sdm_next = rx_word[`WDP_SDM_BIT];
          en_next = rx_word[`WDP_EN_BIT];
          cnt_next = 24'd0;
          if (new_mc == `WDP_MC_SLEEP) begin
            state_next = ST_SLP_ENTRY;
            rst_low_next = 1'b1; // RULE_06
          end else if (wd_off(new_pc, new_mc)) begin
            state_next = ST_WDOFF; // RULE_14
          end else begin
            state_next = ST_RUN;
          end
        end else if (state_reg == ST_INIT && cnt_reg >= INIT_TICKS) begin
          state_next = ST_RST; // RULE_12
          rsrc_next = `WDP_RS_WD_INIT;
          rst_low_next = 1'b1;
          cnt_next = 24'd0;
        end else if (state_reg == ST_RUN && cnt_reg >= period_ticks) begin
          state_next = ST_RST;
          rsrc_next = `WDP_RS_WD_OVF;
          rst_low_next = 1'b1;
          cnt_next = 24'd0;
        end else if (state_reg == ST_WDOFF) begin
          cnt_next = 24'd0; // RULE_14
        end
      end
      ST_SLP_ENTRY: begin
        supply_next = 1'b0; // RULE_07
        cnt_next = 24'd0;
        state_next = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake_event) begin
          state_next = ST_RST;
          rsrc_next = `WDP_RS_LOCAL_WAKE;
          supply_next = 1'b1;
          cnt_next = 24'd0;
        end else if (sleep_off) begin
          cnt_next = 24'd0; // RULE_06
        end else if (cnt_reg >= period_ticks) begin
          state_next = ST_RST;
          rsrc_next = `WDP_RS_CYCLIC;
          supply_next = 1'b1;
          cnt_next = 24'd0;
        end
      end
      ST_RST: begin
        rst_low_next = 1'b1;
        if (cnt_reg >= RST_TICKS) begin
          state_next = ST_INIT;
          rst_low_next = 1'b0;
          cnt_next = 24'd0;
        end
      end
      default: begin
        state_next = ST_RST;
        rst_low_next = 1'b1;
        cnt_next = 24'd0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      state_reg <= ST_INIT;
      cnt_reg <= 24'd0;
      acc_reg <= 18'd0;
      rst_low_reg <= 1'b0;
      supply_reg <= 1'b1;
      rsrc_reg <= `WDP_RS_POR;
      om_reg <= `WDP_OM_RESET;
      pc_reg <= `WDP_PC_RESET;
      sdm_reg <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      rst_low_reg <= rst_low_next;
      supply_reg <= supply_next;
      rsrc_reg <= rsrc_next;
      om_reg <= om_next;
      pc_reg <= pc_next;
      sdm_reg <= sdm_next;
      en_reg <= en_next;
    end
  end

  // Outputs straight from flip-flops, except the decoded activity flag
  assign reset_output_n = ~rst_low_reg;
  assign mcu_supply = supply_reg;
  assign mode_code = om_reg;
  assign sdm_out = sdm_reg;
  assign en_out = en_reg;
  assign wd_active = (state_reg == ST_INIT) || (state_reg == ST_RUN) ||
    (state_reg == ST_SLEEP && !sleep_off);
endmodule // wdp_top

// ### test/wdp_top_sva.sv
`timescale 1ns/1ps
module wdp_top_sva (
  input wire clk,
  input wire resetn,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdo,
  input wire spi_sdo_oe,
  input wire reset_output_n,
  input wire mcu_supply,
  input wire [2:0] mode_code,
  input wire sdm_out,
  input wire en_out,
  input wire wd_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic sclk_q;
  logic [4:0] nbit;
  // Counts sclk rises within a frame
  always @(posedge clk) begin
    sclk_q <= spi_sclk;
    if (!resetn || spi_cs_n)
      nbit <= 5'h00;
    else if (spi_sclk && !sclk_q && nbit != 5'h1f)
      nbit <= nbit + 5'h01;
  end
  sequence s_rst_first;
    !reset_output_n && mcu_supply;
  endsequence
  sequence s_supply_off;
    !reset_output_n && !mcu_supply;
  endsequence
  property p_reset_vals;
    $rose(resetn) |-> reset_output_n && mcu_supply && mode_code == 3'h1 && !sdm_out
      && !en_out && wd_active;
  endproperty
  property p_oe;
    spi_sdo_oe == !spi_cs_n;
  endproperty
  property p_hdr_quiet;
    !spi_cs_n && nbit < 5'h04 |-> !spi_sdo;
  endproperty
  property p_idle_low;
    spi_cs_n [*3] |-> !spi_sdo;
  endproperty
  property p_sdo_on_fall;
    !spi_cs_n && $changed(spi_sdo) |-> $past(!spi_sclk);
  endproperty
  property p_mode_hold;
    !spi_cs_n [*3] |-> $stable(mode_code);
  endproperty
  property p_sleep_entry;
    $rose(mode_code == 3'h4) |-> ##[0:2] s_rst_first ##1 s_supply_off;
  endproperty
  property p_supply_after_rst;
    $fell(mcu_supply) |-> $past(!reset_output_n) && !reset_output_n;
  endproperty
  property p_rst_pulse;
    $fell(reset_output_n) |-> !reset_output_n [*8];
  endproperty
  property p_supply_back;
    $rose(mcu_supply) |-> !reset_output_n;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  a_oe: assert property (p_oe) else $error("sdo enable wrong");
  a_hdr_quiet: assert property (p_hdr_quiet) else $error("sdo high in header");
  a_idle_low: assert property (p_idle_low) else $error("sdo high when idle");
  a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("sdo moved off fall");
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved in frame");
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry order");
  a_supply_after_rst: assert property (p_supply_after_rst) else $error("supply cut early");
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
  a_supply_back: assert property (p_supply_back) else $error("supply back out of reset");
endmodule // wdp_top_sva

bind wdp_top wdp_top_sva u_sva (.clk(clk), .resetn(resetn), .spi_sclk(spi_sclk),
  .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
  .reset_output_n(reset_output_n), .mcu_supply(mcu_supply), .mode_code(mode_code),
  .sdm_out(sdm_out), .en_out(en_out), .wd_active(wd_active));

// ### test/wdp_host.sv
`timescale 1ns/1ps
module wdp_host (
  input wire clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire spi_sdo,
  input wire spi_sdo_oe
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // One frame, MSB first; hp is each sclk phase in clk cycles
  task automatic xfer(input logic [15:0] tx, input int hp, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_sdi <= tx[i];
      repeat (hp) @(posedge clk);
      rx[i] = spi_sdo & spi_sdo_oe;
      spi_sclk <= 1'b1;
      repeat (hp) @(posedge clk);
    end
    spi_sclk <= 1'b0;
    repeat (hp) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_sdi <= ~tx[0];
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule // wdp_host

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic resetn;
  logic [1:0] period_prescaler;
  logic [7:0] status_in;
  logic wake_event;
  wire spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  wire reset_output_n, mcu_supply, sdm_out, en_out, wd_active;
  wire [2:0] mode_code;
  int failures;
  int num_checks;
  logic [15:0] rx;
  wdp_top #(.OSC_KHZ(18'd200000), .INIT_TICKS(24'd400), .RST_TICKS(24'd8)) uut (
    .clk(clk), .resetn(resetn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .period_prescaler(period_prescaler), .status_in(status_in), .wake_event(wake_event),
    .reset_output_n(reset_output_n), .mcu_supply(mcu_supply), .mode_code(mode_code),
    .sdm_out(sdm_out), .en_out(en_out), .wd_active(wd_active));
  wdp_host host (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input int lo, input int hi, input int n);
    num_checks++;
    if (n < lo || n > hi) begin
      failures++;
      $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, n);
    end
  endtask
  function automatic logic [15:0] wr(input logic [5:0] pc, input logic [2:0] om);
    return {4'h0, pc, om, 3'b000};
  endfunction
  task automatic rst;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
  endtask
  task automatic wait_rst(input logic lvl, input int lim, output int n);
    n = 0;
    while (reset_output_n !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    #1;
    chk("reset output", {15'h0, lvl}, {15'h0, reset_output_n});
  endtask
  task automatic rd_stat(input logic [3:0] src);
    host.xfer(16'h1000, 2, rx);
    chk("status", {4'h0, src, status_in}, rx);
  endtask
  task automatic t_init;
    int n;
    rst;
    wait_rst(1'b0, 600, n);
    rng("init window", 395, 406, n);
    wait_rst(1'b1, 100, n);
    rd_stat(4'hc);
    $display("init done");
  endtask
  task automatic t_read;
    rst;
    status_in <= 8'h5a;
    host.xfer({4'h1, 6'h09, 3'h2, 3'b110}, 2, rx);
    chk("read only status", 16'h005a, rx);
    chk("mode kept", 16'h0004, {11'h0, mode_code, sdm_out, en_out});
    host.xfer({4'h0, 6'h09, 3'h2, 3'b110}, 5, rx);
    chk("write status", 16'h005a, rx);
    chk("mode written", 16'h000b, {11'h0, mode_code, sdm_out, en_out});
    host.xfer(16'h1000, 2, rx);
    chk("standby status", 16'h005a, rx);
    host.xfer(16'h3000, 2, rx);
    chk("other select", 16'h0000, rx);
    $display("read done");
  endtask
  task automatic t_off;
    rst;
    host.xfer(wr(6'h36, 3'h2), 2, rx);
    chk("standby off", 16'h0, {15'h0, wd_active});
    host.xfer(wr(6'h36, 3'h1), 2, rx);
    chk("normal armed", 16'h1, {15'h0, wd_active});
    $display("off done");
  endtask
  task automatic t_illegal;
    int n;
    logic [15:0] bad [4] = '{wr(6'h0a, 3'h1), wr(6'h00, 3'h1), wr(6'h3f, 3'h1), wr(6'h36, 3'h0)};
    foreach (bad[i]) begin
      rst;
      host.xfer(bad[i], 2, rx);
      chk("illegal reset", 16'h0, {15'h0, reset_output_n});
      chk("illegal ignored", 16'h1, {13'h0, mode_code});
      wait_rst(1'b1, 100, n);
      rd_stat(4'he);
    end
    $display("illegal done");
  endtask
  task automatic t_sleep;
    int n;
    rst;
    host.xfer(wr(6'h36, 3'h4), 2, rx);
    repeat (3000) @(posedge clk);
    #1;
    chk("sleep held", 16'h0, {14'h0, reset_output_n, mcu_supply});
    chk("sleep wd off", 16'h0, {15'h0, wd_active});
    @(posedge clk);
    wake_event <= 1'b1;
    wait_rst(1'b1, 200, n);
    chk("wake supply", 16'h1, {15'h0, mcu_supply});
    @(posedge clk);
    wake_event <= 1'b0;
    rd_stat(4'h9);
    $display("sleep done");
  endtask
  task automatic t_period;
    int n;
    logic [1:0] pre [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    logic [2:0] om [6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h7};
    int ms [6] = '{4, 6, 10, 14, 20, 20};
    for (int i = 0; i < 6; i++) begin
      rst;
      period_prescaler <= pre[i];
      host.xfer(wr(6'h09, om[i]), 2, rx);
      wait_rst(1'b0, ms[i] * 512 + 100, n);
      rng("period", ms[i] * 512 - 8, ms[i] * 512 + 8, n);
      wait_rst(1'b1, 100, n);
      rd_stat(4'hb);
    end
    $display("period done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    period_prescaler = 2'h0;
    status_in = 8'h00;
    wake_event = 1'b0;
    failures = 0;
    num_checks = 0;
    t_init;
    t_read;
    t_off;
    t_illegal;
    t_sleep;
    t_period;
    end_of_test;
  end
  initial begin
    #500000;
    failures++;
    $display("Error run time expected finish seen timeout");
    end_of_test;
  end
endmodule // testbench
